//--- src/dsos_output_selector.sv
// Status output selector for the open collector terminal and relay
`timescale 1ns/1ps

// How it works
// RULE1: Fault code drives output from fault mask
// RULE2: Mask bits: low volt, other trip, restart
// RULE3: Condition one: preset near output frequency
// RULE4: Level and band 0-400 Hz, capped
// RULE5: Condition two: preset equals level, plus one
// RULE6: Condition three: running near detect level
// RULE7: Condition four: accel/decel threshold with hysteresis
// RULE8: Condition five inverts condition four
// RULE9: Over-voltage trip above 400/820 V
// RULE10: Low-voltage trip below 180/360 V
// RULE11: Heatsink overheat asserts output
// RULE12: Command loss asserts output
// RULE13: Running: run command and output voltage
// RULE14: Stopped with no run command
// RULE15: Constant speed, no accel or decel
// RULE16: Waiting for run command, no trip
// RULE17: Fan trip alarm when continuing operation
// RULE18: Brake signal when external brake used
// RULE19: Link error routing field, two bits
// RULE20: Link error only after persisting
// RULE21: Code 5 shows motor overload
// RULE22: Code 7 shows stall regardless of prevention
// RULE23: Outputs registered, follow condition each cycle
// RULE24: Reset gives defaults, outputs low
module dsos_output_selector
#(
	parameter longint LINK_ERR_CYCLES = dsos_pkg::LINK_ERR_CYCLES,
	parameter int LINK_CW = 24
)
(
	input wire logic mclk,
	input wire logic reset,
	input dsos_pkg::dsos_status_type status,
	input wire logic [dsos_pkg::FREQ_W-1:0] presetFreq,
	input wire logic [dsos_pkg::FREQ_W-1:0] outFreq,
	input wire logic [dsos_pkg::FREQ_W-1:0] maxFrequency,
	input wire logic [dsos_pkg::VOLT_W-1:0] dcLinkVolts,
	input wire logic highVoltClass,
	input wire logic [7:0] autoRestartCount,
	input wire logic fanTripBehaviour,
	input wire logic keypadCommError,
	input wire logic levelWrite,
	input wire logic [dsos_pkg::FREQ_W-1:0] levelValue,
	input wire logic bandWrite,
	input wire logic [dsos_pkg::FREQ_W-1:0] bandValue,
	input wire logic termSelWrite,
	input wire logic [dsos_pkg::SEL_W-1:0] termSelValue,
	input wire logic relaySelWrite,
	input wire logic [dsos_pkg::SEL_W-1:0] relaySelValue,
	input wire logic maskWrite,
	input wire logic [2:0] maskValue,
	input wire logic linkSelWrite,
	input wire logic [1:0] linkSelValue,
	output logic openCollectorOutput,
	output logic relayContacts,
	output logic linkErrorFlag,
	output logic overVoltTrip,
	output logic lowVoltTrip,
	output logic settingRejected,
	output logic [dsos_pkg::FREQ_W-1:0] freqDetectLevel,
	output logic [dsos_pkg::FREQ_W-1:0] freqDetectBandwidth,
	output logic [dsos_pkg::SEL_W-1:0] terminalOutputSelect,
	output logic [dsos_pkg::SEL_W-1:0] relayOutputSelect,
	output logic [2:0] faultRelayMask,
	output logic [1:0] linkErrorOutputSelect
);
	import dsos_pkg::*;

	// ****************************************
	// State and local signals
	// ****************************************
	typedef struct packed {
		logic [FREQ_W-1:0] level;
		logic [FREQ_W-1:0] band;
		logic [SEL_W-1:0] termSel;
		logic [SEL_W-1:0] relaySel;
		logic [2:0] mask;
		logic [1:0] linkSel;
		logic termOut;
		logic relayOut;
		logic ovTrip;
		logic uvTrip;
		logic rejected;
	} dsos_state_type;

	dsos_state_type s;
	dsos_state_type next_s;
	dsos_fdt_type fdt;
	logic linkError;
	logic [19:0] cond;
	logic ovNow;
	logic uvNow;
	logic anyTrip;
	logic faultOut;
	logic [FREQ_W-1:0] freqCap;

	if (LINK_ERR_CYCLES < 1)
		$error("dsos_output_selector: LINK_ERR_CYCLES must be positive");
	if ((longint'(1) << LINK_CW) < LINK_ERR_CYCLES)
		$error("dsos_output_selector: LINK_CW too narrow");

	// ****************************************
	// Helpers
	// ****************************************

	// Pick one condition by selection code; unknown codes read low
	function automatic logic pickCond(input logic [SEL_W-1:0] code,
		input logic [19:0] c);
		if (code <= SEL_LAST)
			pickCond = c[code];
		else
			pickCond = 1'b0;
	endfunction

	// A frequency setting is legal up to 400 Hz and the maximum
	function automatic logic freqOk(input logic [FREQ_W-1:0] v,
		input logic [FREQ_W-1:0] cap);
		freqOk = v <= cap;
	endfunction

	// ****************************************
	// Sub blocks
	// ****************************************
	dsos_freq_detect
	#(
		.FW(FREQ_W)
	)
	u_freq
	(
		.mclk(mclk),
		.reset(reset),
		.presetFreq(presetFreq),
		.outFreq(outFreq),
		.level(s.level),
		.band(s.band),
		.accel(status.accel),
		.decel(status.decel),
		.fdt(fdt)
	);

	dsos_link_error
	#(
		.CW(LINK_CW),
		.HOLD(LINK_ERR_CYCLES)
	)
	u_link
	(
		.mclk(mclk),
		.reset(reset),
		.commError(keypadCommError),
		.linkError(linkError)
	);

	// ****************************************
	// Voltage trips
	// ****************************************

	// Thresholds switch with the voltage class strap
	assign ovNow = dcLinkVolts > (highVoltClass ? OV_HIGH_CLASS
		: OV_LOW_CLASS); // see RULE9
	assign uvNow = dcLinkVolts < (highVoltClass ? UV_HIGH_CLASS
		: UV_LOW_CLASS); // see RULE10
	assign anyTrip = ovNow || uvNow || status.otherTrip;

	// ****************************************
	// Fault output from the mask
	// ****************************************

	// Restart bit is a level: it holds while tries are configured
	assign faultOut = (s.mask[MASK_LOW_VOLT] && uvNow)
		|| (s.mask[MASK_OTHER_TRIP] && (ovNow || status.otherTrip))
		|| (s.mask[MASK_RESTART] && (autoRestartCount != 8'h00));
		// see RULE2

	// ****************************************
	// Condition vector, indexed by selection code
	// ****************************************
	always_comb
	begin
		cond = '0;
		cond[SEL_FDT1] = fdt.match; // see RULE3
		cond[SEL_FDT2] = fdt.levelMatch; // see RULE5
		cond[SEL_FDT3] = fdt.window; // see RULE6
		cond[SEL_FDT4] = fdt.threshold; // see RULE7
		cond[SEL_FDT5] = fdt.thresholdInv; // see RULE8
		cond[SEL_MOTOR_OL] = status.motorOverload; // see RULE21
		cond[SEL_DRIVE_OL] = status.driveOverload;
		cond[SEL_STALL] = status.stall; // see RULE22
		cond[SEL_OVER_VOLT] = ovNow; // see RULE9
		cond[SEL_LOW_VOLT] = uvNow; // see RULE10
		cond[SEL_HEATSINK] = status.heatsinkHot; // see RULE11
		cond[SEL_CMD_LOSS] = status.cmdLoss; // see RULE12
		cond[SEL_RUNNING] = status.runCmd
			&& status.outputActive; // see RULE13
		cond[SEL_STOPPED] = status.stopped
			&& !status.runCmd; // see RULE14
		cond[SEL_CONST] = status.runCmd && status.outputActive
			&& !status.accel && !status.decel; // see RULE15
		cond[SEL_SEARCH] = status.speedSearch;
		cond[SEL_WAIT_RUN] = status.waitRun && !anyTrip; // see RULE16
		cond[SEL_FAULT] = faultOut; // see RULE1
		cond[SEL_FAN] = status.fanTrip
			&& !fanTripBehaviour; // see RULE17
		cond[SEL_BRAKE] = status.brakeUse
			&& status.brakeCmd; // see RULE18
	end

	// ****************************************
	// Next state
	// ****************************************

	// Settings cap at the lower of 400 Hz and the maximum frequency
	assign freqCap = (maxFrequency < FREQ_SET_MAX) ? maxFrequency
		: FREQ_SET_MAX;

	// Illegal writes keep the old setting and pulse the reject flag
	always_comb
	begin
		next_s = s;
		next_s.rejected = 1'b0;
		if (levelWrite)
		begin
			if (freqOk(levelValue, freqCap))
				next_s.level = levelValue; // see RULE4
			else
				next_s.rejected = 1'b1; // see RULE4
		end
		if (bandWrite)
		begin
			if (freqOk(bandValue, freqCap))
				next_s.band = bandValue; // see RULE4
			else
				next_s.rejected = 1'b1; // see RULE4
		end
		if (termSelWrite)
		begin
			if (termSelValue <= SEL_LAST)
				next_s.termSel = termSelValue;
			else
				next_s.rejected = 1'b1;
		end
		if (relaySelWrite)
		begin
			if (relaySelValue <= SEL_LAST)
				next_s.relaySel = relaySelValue;
			else
				next_s.rejected = 1'b1;
		end
		if (maskWrite)
			next_s.mask = maskValue;
		if (linkSelWrite)
			next_s.linkSel = linkSelValue; // see RULE19
		// Outputs are recomputed every cycle from live conditions
		next_s.termOut = pickCond(s.termSel, cond)
			|| (s.linkSel[LINK_TO_TERM] && linkError); // see RULE23
		next_s.relayOut = pickCond(s.relaySel, cond)
			|| (s.linkSel[LINK_TO_RELAY] && linkError); // see RULE19
		next_s.ovTrip = ovNow;
		next_s.uvTrip = uvNow;
	end

	// ****************************************
	// State register
	// ****************************************

	// Reset loads defaults and holds the terminal and relay outputs low
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			s <= '0;
			s.level <= LEVEL_RESET; // see RULE24
			s.band <= BAND_RESET; // see RULE24
			s.termSel <= TERM_SEL_RESET; // see RULE24
			s.relaySel <= RELAY_SEL_RESET; // see RULE24
			s.mask <= MASK_RESET;
			s.linkSel <= LINK_SEL_RESET;
		end
		else
			s <= next_s; // see RULE23
	end

	// ****************************************
	// Outputs
	// ****************************************

	// Every output is a flip-flop
	assign openCollectorOutput = s.termOut;
	assign relayContacts = s.relayOut;
	assign linkErrorFlag = linkError; // see RULE20
	assign overVoltTrip = s.ovTrip;
	assign lowVoltTrip = s.uvTrip;
	assign settingRejected = s.rejected;
	assign freqDetectLevel = s.level;
	assign freqDetectBandwidth = s.band;
	assign terminalOutputSelect = s.termSel;
	assign relayOutputSelect = s.relaySel;
	assign faultRelayMask = s.mask;
	assign linkErrorOutputSelect = s.linkSel;
endmodule

//--- common/dsos_pkg.sv
// Constants and carrier types for the drive status output selector
package dsos_pkg;
	// ****************************************
	// Output selection codes
	// ****************************************
	localparam int SEL_W = 5;
	localparam logic [4:0] SEL_FDT1 = 5'h00;
	localparam logic [4:0] SEL_FDT2 = 5'h01;
	localparam logic [4:0] SEL_FDT3 = 5'h02;
	localparam logic [4:0] SEL_FDT4 = 5'h03;
	localparam logic [4:0] SEL_FDT5 = 5'h04;
	localparam logic [4:0] SEL_MOTOR_OL = 5'h05;
	localparam logic [4:0] SEL_DRIVE_OL = 5'h06;
	localparam logic [4:0] SEL_STALL = 5'h07;
	localparam logic [4:0] SEL_OVER_VOLT = 5'h08;
	localparam logic [4:0] SEL_LOW_VOLT = 5'h09;
	localparam logic [4:0] SEL_HEATSINK = 5'h0a;
	localparam logic [4:0] SEL_CMD_LOSS = 5'h0b;
	localparam logic [4:0] SEL_RUNNING = 5'h0c;
	localparam logic [4:0] SEL_STOPPED = 5'h0d;
	localparam logic [4:0] SEL_CONST = 5'h0e;
	localparam logic [4:0] SEL_SEARCH = 5'h0f;
	localparam logic [4:0] SEL_WAIT_RUN = 5'h10;
	localparam logic [4:0] SEL_FAULT = 5'h11;
	localparam logic [4:0] SEL_FAN = 5'h12;
	localparam logic [4:0] SEL_BRAKE = 5'h13;
	localparam logic [4:0] SEL_LAST = SEL_BRAKE;
	localparam logic [4:0] TERM_SEL_RESET = SEL_RUNNING;
	localparam logic [4:0] RELAY_SEL_RESET = SEL_FAULT;

	// ****************************************
	// Fault mask and link error routing fields
	// ****************************************
	localparam int MASK_LOW_VOLT = 0;
	localparam int MASK_OTHER_TRIP = 1;
	localparam int MASK_RESTART = 2;
	localparam logic [2:0] MASK_RESET = 3'h2;
	localparam int LINK_TO_TERM = 0;
	localparam int LINK_TO_RELAY = 1;
	localparam logic [1:0] LINK_SEL_RESET = 2'h0;

	// ****************************************
	// Frequencies in 0.01 Hz steps, volts in 1 V steps
	// ****************************************
	localparam int FREQ_W = 16;
	localparam logic [15:0] FREQ_SET_MAX = 16'h9c40;
	localparam logic [15:0] LEVEL_RESET = 16'h0bb8;
	localparam logic [15:0] BAND_RESET = 16'h03e8;
	localparam int VOLT_W = 10;
	localparam logic [9:0] OV_LOW_CLASS = 10'h190;
	localparam logic [9:0] OV_HIGH_CLASS = 10'h334;
	localparam logic [9:0] UV_LOW_CLASS = 10'h0b4;
	localparam logic [9:0] UV_HIGH_CLASS = 10'h168;

	// ****************************************
	// Timing
	// ****************************************
	localparam longint CLK_HZ = 125000000;
	localparam longint LINK_ERR_TIME_MS = 100;
	localparam longint LINK_ERR_CYCLES = LINK_ERR_TIME_MS * CLK_HZ / 1000;

	// Drive conditions sampled every cycle
	typedef struct packed {
		logic otherTrip;
		logic motorOverload;
		logic driveOverload;
		logic stall;
		logic heatsinkHot;
		logic cmdLoss;
		logic runCmd;
		logic outputActive;
		logic stopped;
		logic accel;
		logic decel;
		logic speedSearch;
		logic waitRun;
		logic fanTrip;
		logic brakeUse;
		logic brakeCmd;
	} dsos_status_type;

	// Frequency detector results
	typedef struct packed {
		logic match;
		logic levelMatch;
		logic window;
		logic threshold;
		logic thresholdInv;
	} dsos_fdt_type;
endpackage

//--- src/dsos_freq_detect.sv
// Five frequency detection comparators
`timescale 1ns/1ps
module dsos_freq_detect
#(
	parameter int FW = 16
)
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic [FW-1:0] presetFreq,
	input wire logic [FW-1:0] outFreq,
	input wire logic [FW-1:0] level,
	input wire logic [FW-1:0] band,
	input wire logic accel,
	input wire logic decel,
	output dsos_pkg::dsos_fdt_type fdt
);
	import dsos_pkg::*;

	typedef struct packed {
		logic threshold;
	} dsos_fd_state_type;

	dsos_fd_state_type s;
	dsos_fd_state_type next_s;
	logic [FW-1:0] halfBand;
	logic [FW-1:0] lowThr;

	// Distance between two frequencies
	function automatic logic [FW-1:0] absDiff(input logic [FW-1:0] a,
		input logic [FW-1:0] b);
		absDiff = (a > b) ? a - b : b - a;
	endfunction

	if (FW < 2)
		$error("dsos_freq_detect: FW too small");

	// Half band; the lower threshold saturates at zero
	assign halfBand = band >> 1;
	assign lowThr = (level > halfBand) ? level - halfBand : '0;

	// Threshold output holds at constant speed, giving hysteresis
	always_comb
	begin
		next_s = s;
		if (accel)
			next_s.threshold = outFreq >= level; // see RULE7
		else if (decel)
			next_s.threshold = outFreq > lowThr; // see RULE7
		fdt.match = absDiff(presetFreq, outFreq) <= halfBand; // see RULE3
		fdt.levelMatch = (presetFreq == level) && fdt.match; // see RULE5
		fdt.window = absDiff(level, outFreq) <= halfBand; // see RULE6
		fdt.threshold = next_s.threshold;
		fdt.thresholdInv = !next_s.threshold; // see RULE8
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
			s <= '0;
		else
			s <= next_s;
	end
endmodule

//--- src/dsos_link_error.sv
// Persistence filter for keypad link communication errors
`timescale 1ns/1ps
module dsos_link_error
#(
	parameter int CW = 24,
	parameter longint HOLD = 12500000
)
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic commError,
	output logic linkError
);
	import dsos_pkg::*;

	typedef struct packed {
		logic [CW-1:0] count;
		logic flag;
	} dsos_le_state_type;

	dsos_le_state_type s;
	dsos_le_state_type next_s;
	localparam logic [CW-1:0] HOLD_CNT = CW'(HOLD - 1);

	if (HOLD < 1 || HOLD > (longint'(1) << CW))
		$error("dsos_link_error: HOLD does not fit the counter");

	// A single good cycle restarts the wait, so bursts shorter than HOLD cycles never flag
	always_comb
	begin
		next_s = s;
		if (!commError)
		begin
			next_s.count = '0;
			next_s.flag = 1'b0;
		end
		else if (s.count >= HOLD_CNT)
			next_s.flag = 1'b1; // see RULE20
		else
			next_s.count = s.count + 1'b1;
	end

	assign linkError = s.flag;

	always_ff @(posedge mclk)
	begin
		if (reset)
			s <= '0;
		else
			s <= next_s;
	end
endmodule

//--- dv/dsos_load_model.sv
// Load model for the open collector terminal and the relay
`timescale 1ns/1ps
module dsos_load_model
(
	input wire logic driveOn,
	input wire logic relayOn,
	output logic termPin,
	output logic relayClosed
);
	logic outEnN;
	// Enable is low while the transistor pulls the pin down
	assign outEnN = !driveOn;
	// Released pin goes to the pull-up level, never holds the last value
	assign termPin = outEnN ? 1'b1 : 1'b0;
	assign relayClosed = relayOn;
endmodule

//--- dv/dsos_output_selector_chk.sv
// Port level assertions for the status output selector
`timescale 1ns/1ps
module dsos_output_selector_chk
#(
	parameter longint LINK_ERR_CYCLES = 4
)
(
	input wire logic mclk,
	input wire logic reset,
	input dsos_pkg::dsos_status_type status,
	input wire logic [15:0] outFreq,
	input wire logic [15:0] maxFrequency,
	input wire logic [9:0] dcLinkVolts,
	input wire logic highVoltClass,
	input wire logic keypadCommError,
	input wire logic levelWrite,
	input wire logic [15:0] levelValue,
	input wire logic openCollectorOutput,
	input wire logic relayContacts,
	input wire logic linkErrorFlag,
	input wire logic overVoltTrip,
	input wire logic lowVoltTrip,
	input wire logic settingRejected,
	input wire logic [15:0] freqDetectLevel,
	input wire logic [4:0] terminalOutputSelect,
	input wire logic [4:0] relayOutputSelect,
	input wire logic [2:0] faultRelayMask,
	input wire logic [1:0] linkErrorOutputSelect
);
	import dsos_pkg::*;
	logic [31:0] errRun;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	// Run of consecutive link error cycles, cleared by any gap
	always_ff @(posedge mclk)
		if (reset || !keypadCommError)
			errRun <= '0;
		else
			errRun <= errRun + 32'h0000_0001;
	// ****************************************
	// Properties
	// ****************************************
	sequence s_link_relay;
		linkErrorFlag && linkErrorOutputSelect[LINK_TO_RELAY];
	endsequence
	property p_rst;
		$fell(reset) |-> !openCollectorOutput && !relayContacts
			&& terminalOutputSelect == TERM_SEL_RESET
			&& relayOutputSelect == RELAY_SEL_RESET
			&& faultRelayMask == MASK_RESET
			&& linkErrorOutputSelect == 2'h0
			&& freqDetectLevel == 16'h0bb8;
	endproperty
	property p_run;
		terminalOutputSelect == SEL_RUNNING && status.runCmd
			&& status.outputActive |=> openCollectorOutput;
	endproperty
	property p_stop;
		relayOutputSelect == SEL_STOPPED && status.stopped
			&& !status.runCmd |=> relayContacts;
	endproperty
	property p_ov;
		(highVoltClass ? dcLinkVolts > OV_HIGH_CLASS
			: dcLinkVolts > OV_LOW_CLASS) |=> overVoltTrip;
	endproperty
	property p_uv;
		!highVoltClass && dcLinkVolts >= UV_LOW_CLASS |=> !lowVoltTrip;
	endproperty
	property p_uv_on;
		!highVoltClass && dcLinkVolts < UV_LOW_CLASS |=> lowVoltTrip;
	endproperty
	property p_fault;
		relayOutputSelect == SEL_FAULT && status.otherTrip
			&& faultRelayMask[MASK_OTHER_TRIP] |=> relayContacts;
	endproperty
	property p_lvl_rej;
		levelWrite && levelValue > maxFrequency
			|=> settingRejected && $stable(freqDetectLevel);
	endproperty
	property p_link_up;
		$rose(linkErrorFlag) |-> errRun >= 32'(LINK_ERR_CYCLES);
	endproperty
	property p_link_relay;
		s_link_relay |=> relayContacts;
	endproperty
	property p_fdt4;
		terminalOutputSelect == SEL_FDT4 && status.accel && !status.decel
			&& outFreq >= freqDetectLevel |=> openCollectorOutput;
	endproperty
	property p_clear;
		terminalOutputSelect == SEL_HEATSINK && !status.heatsinkHot
			&& !linkErrorFlag |=> !openCollectorOutput;
	endproperty
	// ****************************************
	// Assertions
	// ****************************************
	a_rst: assert property (p_rst)
		else $error("reset state wrong");
	a_run: assert property (p_run)
		else $error("running output missing");
	a_stop: assert property (p_stop)
		else $error("stopped relay missing");
	a_ov: assert property (p_ov)
		else $error("over voltage trip missing");
	a_uv: assert property (p_uv)
		else $error("low voltage trip false");
	a_uv_on: assert property (p_uv_on)
		else $error("low voltage trip missing");
	a_fault: assert property (p_fault)
		else $error("fault relay missing");
	a_lvl_rej: assert property (p_lvl_rej)
		else $error("level above max taken");
	a_link_up: assert property (p_link_up)
		else $error("link error flag too early");
	a_link_relay: assert property (p_link_relay)
		else $error("link error not on relay");
	a_fdt4: assert property (p_fdt4)
		else $error("threshold output missing");
	a_clear: assert property (p_clear)
		else $error("output did not clear");
endmodule

bind dsos_output_selector dsos_output_selector_chk
	#(.LINK_ERR_CYCLES(LINK_ERR_CYCLES)) i_chk (.mclk, .reset, .status,
	.outFreq, .maxFrequency, .dcLinkVolts, .highVoltClass,
	.keypadCommError, .levelWrite, .levelValue, .openCollectorOutput,
	.relayContacts, .linkErrorFlag, .overVoltTrip, .lowVoltTrip,
	.settingRejected, .freqDetectLevel, .terminalOutputSelect,
	.relayOutputSelect, .faultRelayMask, .linkErrorOutputSelect);

//--- dv/dsos_output_selector_bench.sv
// Self-checking bench for the status output selector
`timescale 1ns/1ps
module dsos_output_selector_bench;
	import dsos_pkg::*;
	localparam longint HOLD = 4;
	localparam logic [15:0] F0 = 16'h0bb8;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	dsos_status_type status = '0;
	logic [15:0] presetFreq = 16'h0bb8;
	logic [15:0] outFreq = 16'h0bb8;
	logic [15:0] maxFrequency = 16'h1770;
	logic [9:0] dcLinkVolts = 10'h12c;
	logic highVoltClass = 1'b0;
	logic [7:0] autoRestartCount = 8'h01;
	logic fanTripBehaviour = 1'b0;
	logic keypadCommError = 1'b0;
	logic levelWrite = 1'b0, bandWrite = 1'b0, termSelWrite = 1'b0;
	logic relaySelWrite = 1'b0, maskWrite = 1'b0, linkSelWrite = 1'b0;
	logic [15:0] levelValue = '0, bandValue = '0;
	logic [4:0] termSelValue = '0, relaySelValue = '0;
	logic [2:0] maskValue = '0;
	logic [1:0] linkSelValue = '0;
	logic openCollectorOutput, relayContacts, linkErrorFlag;
	logic overVoltTrip, lowVoltTrip, settingRejected, termPin, relayClosed;
	logic [15:0] freqDetectLevel, freqDetectBandwidth;
	logic [4:0] terminalOutputSelect, relayOutputSelect;
	logic [2:0] faultRelayMask;
	logic [1:0] linkErrorOutputSelect;
	int errors = 0, checks = 0, n;
	// Codes with plain causes, the cause vector and whether it asserts
	logic [4:0] tc [17] = '{5'h05, 5'h06, 5'h07, 5'h0a, 5'h0b, 5'h0c,
		5'h0c, 5'h0d, 5'h0d, 5'h0e, 5'h0e, 5'h0f, 5'h10, 5'h10, 5'h12,
		5'h13, 5'h13};
	logic [15:0] ts [17] = '{16'h4000, 16'h2000, 16'h1000, 16'h0800,
		16'h0400, 16'h0300, 16'h0200, 16'h0080, 16'h0280, 16'h0300,
		16'h0340, 16'h0010, 16'h0008, 16'h8008, 16'h0004, 16'h0003,
		16'h0002};
	logic [16:0] te = 17'h1_fab6;
	dsos_output_selector #(.LINK_ERR_CYCLES(HOLD)) i_dut (.*);
	dsos_load_model i_load (.driveOn(openCollectorOutput),
		.relayOn(relayContacts), .termPin(termPin),
		.relayClosed(relayClosed));
	// Free running 125 MHz clock
	initial
	begin
		forever #4 mclk = !mclk;
	end
	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask
	// One strobe cycle; bits of s pick the settings written together
	task automatic wr(input logic [5:0] s, input logic [15:0] v);
		@(posedge mclk);
		levelValue <= v;
		bandValue <= v;
		termSelValue <= v[4:0];
		relaySelValue <= v[4:0];
		maskValue <= v[2:0];
		linkSelValue <= v[1:0];
		{linkSelWrite, maskWrite, relaySelWrite, termSelWrite, bandWrite,
			levelWrite} <= s;
		@(posedge mclk);
		{linkSelWrite, maskWrite, relaySelWrite, termSelWrite, bandWrite,
			levelWrite} <= 6'h00;
		#1;
	endtask
	// Select a code on both outputs, apply causes, compare both loads
	task automatic run(input logic [4:0] c, input logic [15:0] s,
		input logic e, input logic [15:0] o = 16'h0bb8,
		input logic [9:0] v = 10'h12c, input logic h = 1'b0);
		wr(6'h0c, 16'(c));
		@(posedge mclk);
		status <= s;
		outFreq <= o;
		dcLinkVolts <= v;
		highVoltClass <= h;
		tick(2);
		chk(16'(relayClosed), 16'(e));
		chk(16'(termPin), 16'(!e));
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		repeat (6) @(posedge mclk);
		reset <= 1'b0;
		#1;
		chk(16'({openCollectorOutput, relayContacts}), 16'h0000);
		chk(freqDetectLevel, 16'h0bb8);
		chk(freqDetectBandwidth, 16'h03e8);
		chk(16'(terminalOutputSelect), 16'h000c);
		chk(16'(relayOutputSelect), 16'h0011);
		chk(16'(faultRelayMask), 16'h0002);
		chk(16'(linkErrorOutputSelect), 16'h0000);
		$display("reset test done");
		for (int i = 0; i < 17; i++)
		begin
			run(tc[i], ts[i], te[16-i]);
			@(posedge mclk);
			status <= '0;
			tick(2);
			chk(16'(relayClosed), 16'h0000);
		end
		@(posedge mclk);
		fanTripBehaviour <= 1'b1;
		run(SEL_FAN, 16'h0004, 0);
		$display("condition table test done");
		run(SEL_OVER_VOLT, 0, 1, F0, 10'h191, 0);
		chk(16'(overVoltTrip), 16'h0001);
		run(SEL_OVER_VOLT, 0, 0, F0, 10'h190, 0);
		run(SEL_OVER_VOLT, 0, 1, F0, 10'h335, 1);
		run(SEL_OVER_VOLT, 0, 0, F0, 10'h334, 1);
		run(SEL_LOW_VOLT, 0, 1, F0, 10'h0b3, 0);
		chk(16'(lowVoltTrip), 16'h0001);
		run(SEL_LOW_VOLT, 0, 0, F0, 10'h0b4, 0);
		run(SEL_LOW_VOLT, 0, 1, F0, 10'h167, 1);
		run(SEL_LOW_VOLT, 0, 0, F0, 10'h168, 1);
		$display("voltage test done");
		run(SEL_FAULT, 16'h8000, 1);
		run(SEL_FAULT, 0, 0, F0, 10'h0b3, 0);
		wr(6'h10, 16'h0001);
		run(SEL_FAULT, 0, 1, F0, 10'h0b3, 0);
		run(SEL_FAULT, 16'h8000, 0);
		wr(6'h10, 16'h0004);
		run(SEL_FAULT, 0, 1);
		@(posedge mclk);
		autoRestartCount <= 8'h00;
		run(SEL_FAULT, 0, 0);
		wr(6'h10, 16'h0000);
		run(SEL_FAULT, 16'h8000, 0);
		$display("fault mask test done");
		wr(6'h01, 16'h0bb9);
		chk(16'(settingRejected), 16'h0000);
		run(SEL_FDT2, 0, 0);
		wr(6'h01, 16'h1771);
		chk(16'(settingRejected), 16'h0001);
		chk(freqDetectLevel, 16'h0bb9);
		wr(6'h04, 16'h0014);
		chk(16'(settingRejected), 16'h0001);
		chk(16'(terminalOutputSelect), 16'h0001);
		wr(6'h01, F0);
		wr(6'h02, 16'h03e8);
		chk(freqDetectBandwidth, 16'h03e8);
		// A large maximum must still leave the 400 Hz ceiling in force
		@(posedge mclk);
		maxFrequency <= 16'hffff;
		wr(6'h02, 16'h9c41);
		chk(16'(settingRejected), 16'h0001);
		chk(freqDetectBandwidth, 16'h03e8);
		$display("settings test done");
		run(SEL_FDT1, 0, 1, 16'h09c4);
		run(SEL_FDT1, 0, 0, 16'h09c3);
		run(SEL_FDT2, 0, 1);
		run(SEL_FDT3, 0, 1, 16'h0dac);
		run(SEL_FDT3, 0, 0, 16'h0dad);
		run(SEL_FDT4, 16'h0040, 1);
		run(SEL_FDT4, 16'h0040, 0, 16'h0bb7);
		run(SEL_FDT4, 16'h0020, 1, 16'h09c5);
		run(SEL_FDT4, 16'h0020, 0, 16'h09c4);
		run(SEL_FDT5, 16'h0020, 1, 16'h09c4);
		run(SEL_FDT5, 16'h0040, 0);
		$display("frequency detect test done");
		wr(6'h20, 16'h0003);
		run(SEL_BRAKE, 16'h0002, 0);
		@(posedge mclk);
		keypadCommError <= 1'b1;
		repeat (3) @(posedge mclk);
		keypadCommError <= 1'b0;
		tick(2);
		chk(16'(linkErrorFlag), 16'h0000);
		@(posedge mclk);
		keypadCommError <= 1'b1;
		n = 0;
		#1;
		while (linkErrorFlag !== 1'b1 && n < 20)
		begin
			tick(1);
			n++;
		end
		if (n == 20)
		begin
			errors++;
			give_verdict;
		end
		chk(16'(n), 16'(HOLD));
		tick(1);
		chk(16'({relayClosed, termPin}), 16'h0002);
		// Bit 0 alone routes the error to the terminal only
		wr(6'h20, 16'h0001);
		tick(1);
		chk(16'({relayClosed, termPin}), 16'h0000);
		@(posedge mclk);
		keypadCommError <= 1'b0;
		tick(2);
		chk(16'({linkErrorFlag, relayClosed}), 16'h0000);
		$display("link error test done");
		give_verdict;
	end
endmodule
